// ===== hdl/pcplc_top.sv
module pcplc_top
    import pcplc_pkg::*;
(
    // system
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    // receive compare inputs
    input  wire logic        rx_word_valid,
    input  wire logic [7:0]  rx_word,
    input  wire logic [7:0]  code_detect_pattern,
    input  wire logic        buf1_word_valid,
    input  wire logic [7:0]  buf1_word,
    // capture control
    output logic             buf0_accumulate,
    output logic             buf1_accumulate,
    // bit error counter value and counter preload outputs
    output logic      [7:0]  bit_error_rate_counter,
    output logic             checksum_error_load,
    output logic      [7:0]  checksum_error_value,
    output logic             remote_error_bit_load,
    output logic      [7:0]  remote_error_bit_value,
    output logic             line_violation_load,
    output logic      [15:0] line_violation_value,
    output logic             frame_align_error_load,
    output logic      [7:0]  frame_align_error_value,
    output logic             alarm_crc_run_load,
    output logic      [7:0]  alarm_crc_run_value
);
    logic [7:0]        cmp_pattern_ff;
    logic [7:0]        trig_ctl_ff;
    logic [7:0]        strobes_ff;
    logic [7:0]        ber_pre_ff;
    logic [7:0]        rc_pre_ff;
    logic [7:0]        ef_pre_ff;
    logic [7:0]        bpv_hi_ff;
    logic [7:0]        bpv_lo_ff;
    logic [7:0]        ec_pre_ff;
    logic [7:0]        crc_pre_ff;
    logic [1:0]        mode_ff;
    logic [7:0]        ber_cnt_ff;
    logic [7:0]        nxt_ber_cnt;
    logic [31:0]       prdata_ff;
    logic [31:0]       nxt_prdata;
    logic [LD_NUM-1:0] load_rise;
    logic              wr_en;
    logic              rd_en;
    logic              addr_ok;
    logic              addr_aln;
    logic              addr_pg;
    logic              rd_stat;
    logic [7:0]        reg_idx;
    logic [7:0]        wbyte;
    logic              serial_mode;
    logic              cdw_match;
    logic              load_seen_ff;

    // byte address is four times the register index
    assign reg_idx  = paddr[9:2];
    assign wbyte    = pwdata[7:0];
    assign addr_aln = (paddr[1:0] == 2'h0);
    assign addr_pg  = (paddr[11:10] == 2'h0);
    assign addr_ok  = addr_aln && addr_pg && idx_mapped(reg_idx);
    assign wr_en    = psel & penable & pwrite & addr_ok;
    assign rd_en    = psel & ~penable & ~pwrite;
    // status read completes in the access cycle
    assign rd_stat  = psel & penable & ~pwrite & addr_ok & (reg_idx == IDX_CAPTURE_STAT);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_ok;
    assign prdata   = prdata_ff;

    function automatic logic idx_mapped(input logic [7:0] idx);
        case (idx)
            IDX_BER_CMP,
            IDX_TRIG_CTL,
            IDX_LOAD_STROBES,
            IDX_BER_PRELOAD,
            IDX_RC_PRELOAD,
            IDX_EF_PRELOAD,
            IDX_BPV_PRE_HI,
            IDX_BPV_PRE_LO,
            IDX_EC_PRELOAD,
            IDX_CRC_PRELOAD,
            IDX_MODE_CTL,
            IDX_CAPTURE_STAT,
            IDX_BER_COUNT: idx_mapped = 1'b1;
            default:       idx_mapped = 1'b0;
        endcase
    endfunction

    // write strobe for one register index
    function automatic logic wr_hit(input logic [7:0] want);
        wr_hit = wr_en && (reg_idx == want);
    endfunction

    function automatic logic [3:0] ones8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int k = 0; k < 8; k++) begin
            n = n + {3'h0, v[k]};
        end
        ones8 = n;
    endfunction

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmp_pattern_ff <= RST_BYTE;
        end else if (wr_en && reg_idx == IDX_BER_CMP) begin
            cmp_pattern_ff <= wbyte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trig_ctl_ff <= RST_BYTE;
        end else if (wr_en && reg_idx == IDX_TRIG_CTL) begin
            trig_ctl_ff <= wbyte;
        end
    end

    // top two strobe bits unused, kept zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strobes_ff <= RST_BYTE;
        end else if (wr_en && reg_idx == IDX_LOAD_STROBES) begin
            strobes_ff <= {2'h0, wbyte[LD_NUM-1:0]};
        end
    end

    // preloads cleared at reset so a load never passes unknowns
    // bit error rate preload
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ber_pre_ff <= RST_BYTE;
        end else if (wr_hit(IDX_BER_PRELOAD)) begin
            ber_pre_ff <= wbyte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rc_pre_ff <= RST_BYTE;
        end else if (wr_hit(IDX_RC_PRELOAD)) begin
            rc_pre_ff <= wbyte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ef_pre_ff <= RST_BYTE;
        end else if (wr_hit(IDX_EF_PRELOAD)) begin
            ef_pre_ff <= wbyte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bpv_hi_ff <= RST_BYTE;
        end else if (wr_hit(IDX_BPV_PRE_HI)) begin
            bpv_hi_ff <= wbyte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bpv_lo_ff <= RST_BYTE;
        end else if (wr_hit(IDX_BPV_PRE_LO)) begin
            bpv_lo_ff <= wbyte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ec_pre_ff <= RST_BYTE;
        end else if (wr_hit(IDX_EC_PRELOAD)) begin
            ec_pre_ff <= wbyte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            crc_pre_ff <= RST_BYTE;
        end else if (wr_hit(IDX_CRC_PRELOAD)) begin
            crc_pre_ff <= wbyte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_ff <= MODE_RST;
        end else if (wr_en && reg_idx == IDX_MODE_CTL) begin
            mode_ff <= wbyte[1:0];
        end
    end

    assign serial_mode = (mode_ff == MODE_SERIAL);

    pcplc_edge #(
        .W (LD_NUM)
    ) u_edge (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .level_in   (strobes_ff[LD_NUM-1:0]),
        .enable     (serial_mode),
        .rise_pulse (load_rise)
    );

    assign checksum_error_load     = load_rise[LD_CRC];
    assign checksum_error_value    = crc_pre_ff;
    assign remote_error_bit_load   = load_rise[LD_EC];
    assign remote_error_bit_value  = ec_pre_ff;
    assign line_violation_load     = load_rise[LD_BPV];
    assign line_violation_value    = {bpv_hi_ff, bpv_lo_ff};
    assign frame_align_error_load  = load_rise[LD_EF];
    assign frame_align_error_value = ef_pre_ff;
    assign alarm_crc_run_load      = load_rise[LD_RC];
    assign alarm_crc_run_value     = rc_pre_ff;

    always_comb begin
        nxt_ber_cnt = ber_cnt_ff;
        if (load_rise[LD_BER]) begin
            nxt_ber_cnt = ber_pre_ff;
        end else if (buf1_word_valid) begin
            nxt_ber_cnt = ber_cnt_ff + {4'h0, ones8(buf1_word ^ cmp_pattern_ff)};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ber_cnt_ff <= RST_BYTE;
        end else begin
            ber_cnt_ff <= nxt_ber_cnt;
        end
    end

    assign bit_error_rate_counter = ber_cnt_ff;

    assign cdw_match = (rx_word == code_detect_pattern);

    pcplc_trig u_trig0 (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .cmp_valid      (rx_word_valid),
        .cmp_match      (cdw_match),
        .begin_on_miss  (trig_ctl_ff[TRG_B0_BEGIN_MISS]),
        .begin_on_match (trig_ctl_ff[TRG_B0_BEGIN_MATCH]),
        .end_on_miss    (trig_ctl_ff[TRG_B0_END_MISS]),
        .end_on_match   (trig_ctl_ff[TRG_B0_END_MATCH]),
        .accumulate     (buf0_accumulate)
    );

    pcplc_trig u_trig1 (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .cmp_valid      (rx_word_valid),
        .cmp_match      (cdw_match),
        .begin_on_miss  (trig_ctl_ff[TRG_B1_BEGIN_MISS]),
        .begin_on_match (trig_ctl_ff[TRG_B1_BEGIN_MATCH]),
        .end_on_miss    (trig_ctl_ff[TRG_B1_END_MISS]),
        .end_on_match   (trig_ctl_ff[TRG_B1_END_MATCH]),
        .accumulate     (buf1_accumulate)
    );

    // sticky flag: any counter load since last status read; set beats clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            load_seen_ff <= 1'b0;
        end else if (|load_rise) begin
            load_seen_ff <= 1'b1;
        end else if (rd_stat) begin
            load_seen_ff <= 1'b0;
        end
    end

    // read data registered in setup so it is stable through access
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (reg_idx)
            IDX_BER_CMP:      nxt_prdata[7:0] = cmp_pattern_ff;
            IDX_TRIG_CTL:     nxt_prdata[7:0] = trig_ctl_ff;
            IDX_LOAD_STROBES: nxt_prdata[7:0] = strobes_ff;
            IDX_BER_PRELOAD:  nxt_prdata[7:0] = ber_pre_ff;
            IDX_RC_PRELOAD:   nxt_prdata[7:0] = rc_pre_ff;
            IDX_EF_PRELOAD:   nxt_prdata[7:0] = ef_pre_ff;
            IDX_BPV_PRE_HI:   nxt_prdata[7:0] = bpv_hi_ff;
            IDX_BPV_PRE_LO:   nxt_prdata[7:0] = bpv_lo_ff;
            IDX_EC_PRELOAD:   nxt_prdata[7:0] = ec_pre_ff;
            IDX_CRC_PRELOAD:  nxt_prdata[7:0] = crc_pre_ff;
            IDX_MODE_CTL:     nxt_prdata[1:0] = mode_ff;
            IDX_CAPTURE_STAT: nxt_prdata[2:0] = {load_seen_ff, buf1_accumulate, buf0_accumulate};
            IDX_BER_COUNT:    nxt_prdata[7:0] = ber_cnt_ff;
            default:          nxt_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_en) begin
            // misaligned or unmapped reads return zero
            prdata_ff <= addr_ok ? nxt_prdata : 32'h0000_0000;
        end
    end
endmodule

// ===== hdl/pcplc_pkg.sv
package pcplc_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_BER_CMP       = 8'h11;
    localparam logic [7:0] IDX_TRIG_CTL      = 8'h12;
    localparam logic [7:0] IDX_LOAD_STROBES  = 8'h15;
    localparam logic [7:0] IDX_BER_PRELOAD   = 8'h18;
    localparam logic [7:0] IDX_RC_PRELOAD    = 8'h19;
    localparam logic [7:0] IDX_EF_PRELOAD    = 8'h1a;
    localparam logic [7:0] IDX_BPV_PRE_HI    = 8'h1c;
    localparam logic [7:0] IDX_BPV_PRE_LO    = 8'h1d;
    localparam logic [7:0] IDX_EC_PRELOAD    = 8'h1e;
    localparam logic [7:0] IDX_CRC_PRELOAD   = 8'h1f;
    // own registers
    localparam logic [7:0] IDX_MODE_CTL      = 8'h20;
    localparam logic [7:0] IDX_CAPTURE_STAT  = 8'h21;
    localparam logic [7:0] IDX_BER_COUNT     = 8'h22;

    // trigger control bit positions
    localparam int TRG_B0_BEGIN_MISS  = 7;
    localparam int TRG_B0_BEGIN_MATCH = 6;
    localparam int TRG_B1_BEGIN_MISS  = 5;
    localparam int TRG_B1_BEGIN_MATCH = 4;
    localparam int TRG_B0_END_MISS    = 3;
    localparam int TRG_B0_END_MATCH   = 2;
    localparam int TRG_B1_END_MISS    = 1;
    localparam int TRG_B1_END_MATCH   = 0;

    // load strobe bit positions
    localparam int LD_CRC = 5;
    localparam int LD_EC  = 4;
    localparam int LD_BPV = 3;
    localparam int LD_EF  = 2;
    localparam int LD_RC  = 1;
    localparam int LD_BER = 0;
    localparam int LD_NUM = 6;

    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [1:0] MODE_SERIAL  = 2'h0;
    localparam logic [1:0] MODE_RST     = 2'h0;
endpackage

// ===== hdl/pcplc_edge.sv
module pcplc_edge
    import pcplc_pkg::*;
#(
    parameter int W = 6
) (
    // system
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // level in, pulse out
    input  wire logic [W-1:0] level_in,
    input  wire logic         enable,
    output logic      [W-1:0] rise_pulse
);
    logic [W-1:0] prev_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= level_in;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_rise
            assign rise_pulse[i] = enable & level_in[i] & ~prev_ff[i];
        end
    endgenerate
endmodule

// ===== hdl/pcplc_trig.sv
module pcplc_trig
    import pcplc_pkg::*;
(
    // system
    input  wire logic clk_sys,
    input  wire logic rst,
    // comparison result for the selected data
    input  wire logic cmp_valid,
    input  wire logic cmp_match,
    // arm bits
    input  wire logic begin_on_miss,
    input  wire logic begin_on_match,
    input  wire logic end_on_miss,
    input  wire logic end_on_match,
    // capture state
    output logic      accumulate
);
    logic hit_begin;
    logic hit_end;
    logic acc_ff;

    assign hit_begin = cmp_valid & ((begin_on_miss & ~cmp_match) | (begin_on_match & cmp_match));
    assign hit_end   = cmp_valid & ((end_on_miss & ~cmp_match) | (end_on_match & cmp_match));

    // a stop condition wins if both fire on the same word
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_ff <= 1'b0;
        end else if (hit_end) begin
            acc_ff <= 1'b0;
        end else if (hit_begin) begin
            acc_ff <= 1'b1;
        end
    end

    assign accumulate = acc_ff;
endmodule

// ===== tb/pcplc_checker.sv
module pcplc_checker (
    // apb request
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // capture
    input wire logic        rx_word_valid,
    input wire logic [7:0]  rx_word,
    input wire logic [7:0]  code_detect_pattern,
    input wire logic        buf0_accumulate,
    input wire logic        buf1_accumulate,
    // load pulses
    input wire logic        checksum_error_load,
    input wire logic        remote_error_bit_load,
    input wire logic        line_violation_load,
    input wire logic        frame_align_error_load,
    input wire logic        alarm_crc_run_load
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // a pulse needs a strobe write one cycle earlier
    property p_load(ld, int b);
        ld |-> $past(psel && penable && pwrite && paddr == 12'h054 && pwdata[b]);
    endproperty
    AST_LOAD_CRC: assert property (p_load(checksum_error_load, 5))
        else $error("checksum load without strobe write");
    AST_LOAD_EC: assert property (p_load(remote_error_bit_load, 4))
        else $error("remote error load without strobe write");
    AST_LOAD_BPV: assert property (p_load(line_violation_load, 3))
        else $error("violation load without strobe write");
    AST_LOAD_EF: assert property (p_load(frame_align_error_load, 2))
        else $error("frame align load without strobe write");
    AST_LOAD_RC: assert property (p_load(alarm_crc_run_load, 1))
        else $error("alarm run load without strobe write");
    AST_B0_BEGIN: assert property ($rose(buf0_accumulate) |-> $past(rx_word_valid))
        else $error("buffer zero started without word");
    AST_B1_BEGIN: assert property ($rose(buf1_accumulate) |-> $past(rx_word_valid))
        else $error("buffer one started without word");
    AST_B0_END: assert property ($fell(buf0_accumulate) |-> $past(rx_word_valid))
        else $error("buffer zero stopped without word");
    AST_B1_END: assert property ($fell(buf1_accumulate) |-> $past(rx_word_valid))
        else $error("buffer one stopped without word");

    // shadow of the trigger arm byte at byte address 0x48
    logic [7:0] trg_ff;
    logic       word_miss;
    logic       word_hit;
    logic       b0_go;
    logic       b0_halt;
    logic       b1_go;
    logic       b1_halt;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trg_ff <= 8'h00;
        end else if (psel && penable && pwrite && paddr == 12'h048) begin
            trg_ff <= pwdata[7:0];
        end
    end

    assign word_miss = rx_word_valid && (rx_word != code_detect_pattern);
    assign word_hit  = rx_word_valid && (rx_word == code_detect_pattern);
    assign b0_go     = (word_miss && trg_ff[7]) || (word_hit && trg_ff[6]);
    assign b1_go     = (word_miss && trg_ff[5]) || (word_hit && trg_ff[4]);
    assign b0_halt   = (word_miss && trg_ff[3]) || (word_hit && trg_ff[2]);
    assign b1_halt   = (word_miss && trg_ff[1]) || (word_hit && trg_ff[0]);

    // a stop on the same word overrides a start
    sequence s_b0_start;
        b0_go && !b0_halt;
    endsequence
    sequence s_b1_start;
        b1_go && !b1_halt;
    endsequence
    sequence s_b0_stop;
        b0_halt;
    endsequence
    sequence s_b1_stop;
        b1_halt;
    endsequence

    AST_B0_ARMED_BEGIN: assert property (s_b0_start |=> buf0_accumulate)
        else $error("buffer zero missed its armed start");
    AST_B1_ARMED_BEGIN: assert property (s_b1_start |=> buf1_accumulate)
        else $error("buffer one missed its armed start");
    AST_B0_ARMED_END: assert property (s_b0_stop |=> !buf0_accumulate)
        else $error("buffer zero missed its armed stop");
    AST_B1_ARMED_END: assert property (s_b1_stop |=> !buf1_accumulate)
        else $error("buffer one missed its armed stop");
endmodule

bind pcplc_top pcplc_checker pcplc_checker_i (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .rx_word_valid(rx_word_valid),
    .rx_word(rx_word), .code_detect_pattern(code_detect_pattern),
    .buf0_accumulate(buf0_accumulate), .buf1_accumulate(buf1_accumulate),
    .checksum_error_load(checksum_error_load),
    .remote_error_bit_load(remote_error_bit_load),
    .line_violation_load(line_violation_load),
    .frame_align_error_load(frame_align_error_load),
    .alarm_crc_run_load(alarm_crc_run_load)
);

// ===== tb/perf_counter_preload_and_capture_ctl_tb.sv
module perf_counter_preload_and_capture_ctl_tb
    import pcplc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, er;
    logic        rx_word_valid, buf1_word_valid, buf0_accumulate, buf1_accumulate;
    logic        crc_ld, ec_ld, bpv_ld, ef_ld, rc_ld;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  rx_word, code_detect_pattern, buf1_word, ber_cnt;
    logic [7:0]  crc_v, ec_v, ef_v, rc_v;
    logic [15:0] bpv_v;
    logic [5:0]  lv;
    int          mismatches, n_compared;
    logic [7:0]  regs [10] = '{IDX_BER_CMP, IDX_TRIG_CTL, IDX_LOAD_STROBES, IDX_BER_PRELOAD,
        IDX_RC_PRELOAD, IDX_EF_PRELOAD, IDX_BPV_PRE_HI, IDX_BPV_PRE_LO, IDX_EC_PRELOAD,
        IDX_CRC_PRELOAD};
    logic [7:0]  pre [1:5] = '{IDX_RC_PRELOAD, IDX_EF_PRELOAD, IDX_BPV_PRE_HI, IDX_EC_PRELOAD,
        IDX_CRC_PRELOAD};

    assign lv = {crc_ld, ec_ld, bpv_ld, ef_ld, rc_ld, 1'b0};

    pcplc_top pcplc_top_i (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rx_word_valid(rx_word_valid), .rx_word(rx_word),
        .code_detect_pattern(code_detect_pattern), .buf1_word_valid(buf1_word_valid),
        .buf1_word(buf1_word), .buf0_accumulate(buf0_accumulate),
        .buf1_accumulate(buf1_accumulate), .bit_error_rate_counter(ber_cnt),
        .checksum_error_load(crc_ld), .checksum_error_value(crc_v),
        .remote_error_bit_load(ec_ld), .remote_error_bit_value(ec_v),
        .line_violation_load(bpv_ld), .line_violation_value(bpv_v),
        .frame_align_error_load(ef_ld), .frame_align_error_value(ef_v),
        .alarm_crc_run_load(rc_ld), .alarm_crc_run_value(rc_v)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // idle edge first, so back-to-back calls never drive psel twice in one step
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            mismatches++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rxw(input logic [7:0] w, input logic [1:0] e);
        @(posedge clk_sys);
        rx_word_valid <= 1'b1;
        rx_word <= w;
        @(posedge clk_sys);
        rx_word_valid <= 1'b0;
        #1;
        chk("accumulate", e, {buf0_accumulate, buf1_accumulate});
    endtask

    task feed(input logic [7:0] w, input logic [7:0] e);
        @(posedge clk_sys);
        buf1_word_valid <= 1'b1;
        buf1_word <= w;
        @(posedge clk_sys);
        buf1_word_valid <= 1'b0;
        #1;
        chk("ber count", e, ber_cnt);
    endtask

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {rx_word_valid, rx_word, buf1_word_valid, buf1_word} = 18'h0;
        code_detect_pattern = 8'h3c;
        mismatches = 0;
        n_compared = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk("acc reset", 0, {buf0_accumulate, buf1_accumulate});
        for (int i = 0; i < 10; i++) begin
            apb(0, regs[i], 8'h00);
            chk("reset value", 0, rd);
        end
        for (int i = 0; i < 10; i++) apb(1, regs[i], (i == 2) ? 8'hc0 : 8'h81 + 8'(i));
        for (int i = 0; i < 10; i++) begin
            apb(0, regs[i], 8'h00);
            chk("readback", (i == 2) ? 8'h00 : 8'h81 + 8'(i), rd);
        end
        apb(1, 8'h13, 8'hff);
        apb(0, 8'h13, 8'h00);
        chk("unmapped", 32'h1, {rd[30:0], er});
        apb(1, IDX_BPV_PRE_LO, 8'h07);
        for (int b = 1; b < 6; b++) begin
            apb(1, pre[b], 8'h40 + 8'(b));
            apb(1, IDX_LOAD_STROBES, 8'(1 << b));
            #1;
            chk("load pulse", 1 << b, lv);
            apb(1, IDX_LOAD_STROBES, 8'h00);
        end
        chk("violation value", 16'h4307, bpv_v);
        chk("values", 32'h45444241, {crc_v, ec_v, ef_v, rc_v});
        apb(1, IDX_MODE_CTL, 8'h01);
        apb(1, IDX_LOAD_STROBES, 8'h3f);
        #1;
        chk("mode load", 0, lv);
        @(posedge clk_sys);
        #1;
        chk("mode ber", 0, ber_cnt);
        apb(1, IDX_LOAD_STROBES, 8'h00);
        apb(1, IDX_MODE_CTL, 8'h00);
        apb(1, IDX_BER_CMP, 8'ha5);
        apb(1, IDX_BER_PRELOAD, 8'hfc);
        apb(1, IDX_LOAD_STROBES, 8'h01);
        @(posedge clk_sys);
        #1;
        chk("ber load", 8'hfc, ber_cnt);
        feed(8'h5a, 8'h04);
        feed(8'ha4, 8'h05);
        apb(1, IDX_TRIG_CTL, 8'h96);
        rxw(8'h00, 2'b10);
        rxw(8'h3c, 2'b01);
        rxw(8'h11, 2'b10);
        apb(1, IDX_TRIG_CTL, 8'h69);
        rxw(8'h3c, 2'b10);
        rxw(8'h00, 2'b01);
        rxw(8'h3c, 2'b10);
        apb(1, IDX_TRIG_CTL, 8'h00);
        rxw(8'h00, 2'b10);
        rxw(8'h3c, 2'b10);
        apb(0, IDX_CAPTURE_STAT, 8'h00);
        chk("status sticky", 32'h5, rd);
        apb(0, IDX_CAPTURE_STAT, 8'h00);
        chk("status cleared", 32'h1, rd);
        apb(0, IDX_BER_COUNT, 8'h00);
        chk("ber register", 32'h5, rd);
        apb(0, IDX_MODE_CTL, 8'h00);
        chk("mode register", 32'h0, rd);
        print_verdict();
    end
endmodule
